// ---- core/swb_regs.svh ----
/*
 * Register map, field positions, reset values and frame constants of the
 * serial switch register bank. Included by the bank; the synchroniser takes its reset value as a parameter.
 */
`ifndef SWB_REGS_SVH
`define SWB_REGS_SVH

`define SWB_ADDR_SWITCH 7'h01
`define SWB_ADDR_CFG 7'h02
`define SWB_ADDR_STATUS 7'h03
`define SWB_ADDR_BURST 7'h05
`define SWB_ADDR_KEY 7'h0b

`define SWB_SWITCH_RESET 8'h00
`define SWB_CFG_RESET 8'h06
`define SWB_STATUS_RESET 8'h00
`define SWB_BURST_RESET 8'h00
`define SWB_KEY_RESET 8'h00
`define SWB_ZERO8 8'h00

`define SWB_CFG_MASK 8'h07
`define SWB_STATUS_MASK 8'h07
`define SWB_BURST_MASK 8'h01

`define SWB_CFG_ADDR_CHK 2
`define SWB_CFG_CNT_CHK 1
`define SWB_CFG_CRC 0
`define SWB_FLAG_ADDR 2
`define SWB_FLAG_CNT 1
`define SWB_FLAG_CRC 0
`define SWB_BURST_BIT 0

`define SWB_LEN_PLAIN 5'h10
`define SWB_LEN_CRC 5'h18
`define SWB_CMD_RD 15
`define SWB_ADDR_HI 14
`define SWB_ADDR_LO 8
`define SWB_DATA_HI 7
`define SWB_SH_MSB 23
`define SWB_CMD_CRC_LO 8
`define SWB_CMD_HI 15

`define SWB_CLEAR_CMD 16'h6ca9
`define SWB_KEY_FIRST 8'ha3
`define SWB_KEY_SECOND 8'h05
`define SWB_ALIGN 8'h25
`define SWB_CRC_POLY 8'h07
`define SWB_CRC_INIT 8'h00
`define SWB_PIN_IDLE 3'h4

`endif

// ---- core/swb_pkg.sv ----
/*
 * Types shared by the serial switch register bank.
 * Assumes swb_regs.svh for all numeric constants.
 */
package swb_pkg;
    typedef logic [4:0] swb_bitcnt_type;
    typedef enum logic [1:0] {
        SWB_NO_WORD = 2'h0,
        SWB_ONE_WORD = 2'h1,
        SWB_MANY_WORDS = 2'h2
    } swb_words_type;
endpackage

// ---- core/swb_sync.sv ----
/*
 * Three-stage synchroniser with agreement filter for serial pins.
 * Assumes sys_clk, synchronous active-low rst_n and a clock enable.
 */
`timescale 1ns/100ps
module swb_sync #(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] level_q
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s1_q <= RESET_VAL;
            s2_q <= RESET_VAL;
            s3_q <= RESET_VAL;
        end else if (ce) begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // a bit moves only once stages two and three agree
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            level_q <= RESET_VAL;
        end else if (ce) begin
            level_q <= (s2_q & s3_q) | (level_q & (s2_q | s3_q));
        end
    end
endmodule // swb_sync

// ---- core/swb_core.sv ----
/*
 * Register bank of an SPI-controlled octal switch: switch state, error-check
 * configuration, error flags, burst control and reset key, with the serial
 * command decoder. Assumes sys_clk at 10 MHz, serial pins from another domain.
 */
// Summary of operation
// - An eight-bit switch state register at 0x01 holds one bit per switch, bit 7 for switch 8, reset to zero.
// - A switch is closed while its bit is 1 and open while it is 0.
// - The error-check configuration register at 0x02 is read/write and resets to 0x06.
// - Configuration bit 2 enables flagging of accesses to invalid register addresses.
// - Configuration bit 1 enables checking the serial clock count of each frame.
// - Without CRC and burst, a frame must hold exactly 16 serial clocks.
// - With CRC and without burst, a frame must hold exactly 24 serial clocks.
// - In burst mode any nonzero whole multiple of 16, or of 24 with CRC, is accepted.
// - Read-only error flags at 0x03: bit 2 address, bit 1 clock count, bit 0 CRC, reset to zero.
// - Bit 0 of the burst control register at 0x05 enables burst mode and resets to zero.
// - Writing 0xa3 then 0x05 to the reset key register in consecutive commands restores all defaults.
`timescale 1ns/100ps
`include "swb_regs.svh"
module swb_core (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe_n,
    output logic switch_one_close,
    output logic switch_two_close,
    output logic switch_three_close,
    output logic switch_four_close,
    output logic switch_five_close,
    output logic switch_six_close,
    output logic switch_seven_close,
    output logic switch_eight_close
);
    logic [2:0] lvl;
    logic [2:0] prev_q;
    logic sclk_rise, sclk_fall, cs_rise, cs_fall, active;
    logic [23:0] sh_q;
    logic [23:0] sh_nx;
    swb_pkg::swb_bitcnt_type bit_q;
    swb_pkg::swb_bitcnt_type len;
    swb_pkg::swb_words_type word_q;
    logic [7:0] switch_q, cfg_q, flag_q, burst_q, key_q;
    logic armed_q;
    logic [23:0] resp_q;
    logic fresh_q, sdo_q, oe_n_q;
    logic word_done, exec, crc_ok, is_rd, is_clear, addr_ok, do_write, soft_rst, cnt_bad;
    logic [15:0] cmd;
    logic [6:0] addr;
    logic [7:0] data, rd_data, flag_set;

    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] c;
        c = `SWB_CRC_INIT;
        for (int i = `SWB_CMD_HI; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? `SWB_CRC_POLY : `SWB_ZERO8);
        end
        return c;
    endfunction

    swb_sync #(.WIDTH(3), .RESET_VAL(`SWB_PIN_IDLE)) u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .ce(ce),
        .async_in({cs_n, sclk, sdi}),
        .level_q(lvl)
    );

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            prev_q <= `SWB_PIN_IDLE;
        end else if (ce) begin
            prev_q <= lvl;
        end
    end

    assign active = ~lvl[2];
    assign sclk_rise = lvl[1] & ~prev_q[1];
    assign sclk_fall = ~lvl[1] & prev_q[1];
    assign cs_rise = lvl[2] & ~prev_q[2];
    assign cs_fall = ~lvl[2] & prev_q[2];

    // frame length follows the crc setting
    assign len = cfg_q[`SWB_CFG_CRC] ? `SWB_LEN_CRC : `SWB_LEN_PLAIN;
    assign sh_nx = {sh_q[22:0], lvl[0]};
    assign word_done = sclk_rise & active & (bit_q == len - 5'h01);
    // without burst only the first word of a frame is executed
    assign exec = ce & word_done & (burst_q[`SWB_BURST_BIT] | (word_q == swb_pkg::SWB_NO_WORD));
    assign cmd = cfg_q[`SWB_CFG_CRC] ? sh_nx[`SWB_SH_MSB:`SWB_CMD_CRC_LO] : sh_nx[`SWB_CMD_HI:0];
    assign crc_ok = ~cfg_q[`SWB_CFG_CRC] | (crc8(cmd) == sh_nx[`SWB_DATA_HI:0]);
    assign is_rd = cmd[`SWB_CMD_RD];
    assign addr = cmd[`SWB_ADDR_HI:`SWB_ADDR_LO];
    assign data = cmd[`SWB_DATA_HI:0];
    assign is_clear = ~is_rd & (cmd == `SWB_CLEAR_CMD);
    assign addr_ok = (addr == `SWB_ADDR_SWITCH) | (addr == `SWB_ADDR_CFG) | (addr == `SWB_ADDR_BURST)
        | (addr == `SWB_ADDR_KEY) | (is_rd & (addr == `SWB_ADDR_STATUS));
    assign do_write = exec & crc_ok & ~is_rd & addr_ok & ~is_clear;
    assign soft_rst = do_write & (addr == `SWB_ADDR_KEY) & (data == `SWB_KEY_SECOND) & armed_q;
    // count is good only on a word boundary, one word unless burst
    assign cnt_bad = ~((bit_q == 5'h00) & (word_q != swb_pkg::SWB_NO_WORD)
        & (burst_q[`SWB_BURST_BIT] | (word_q == swb_pkg::SWB_ONE_WORD)));

    always_comb begin
        unique case (addr)
            `SWB_ADDR_SWITCH: rd_data = switch_q;
            `SWB_ADDR_CFG: rd_data = cfg_q;
            `SWB_ADDR_STATUS: rd_data = flag_q;
            `SWB_ADDR_BURST: rd_data = burst_q;
            `SWB_ADDR_KEY: rd_data = key_q;
            default: rd_data = `SWB_ZERO8;
        endcase
    end

    always_comb begin
        flag_set = `SWB_ZERO8;
        flag_set[`SWB_FLAG_CRC] = exec & ~crc_ok;
        flag_set[`SWB_FLAG_ADDR] = exec & crc_ok & ~is_clear & ~addr_ok & cfg_q[`SWB_CFG_ADDR_CHK];
        flag_set[`SWB_FLAG_CNT] = ce & cs_rise & cfg_q[`SWB_CFG_CNT_CHK] & cnt_bad;
    end

    // bit and word counting inside a chip-select frame
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sh_q <= '0;
            bit_q <= '0;
            word_q <= swb_pkg::SWB_NO_WORD;
        end else if (ce) begin
            if (!active) begin
                bit_q <= '0;
                word_q <= swb_pkg::SWB_NO_WORD;
            end else if (sclk_rise) begin
                sh_q <= sh_nx;
                if (word_done) begin
                    bit_q <= '0;
                    word_q <= (word_q == swb_pkg::SWB_NO_WORD) ? swb_pkg::SWB_ONE_WORD : swb_pkg::SWB_MANY_WORDS;
                end else begin
                    bit_q <= bit_q + 5'h01;
                end
            end
        end
    end

    // writable registers; reserved bits masked off
    always_ff @(posedge sys_clk) begin
        if (!rst_n || soft_rst) begin
            switch_q <= `SWB_SWITCH_RESET;
            cfg_q <= `SWB_CFG_RESET;
            burst_q <= `SWB_BURST_RESET;
            key_q <= `SWB_KEY_RESET;
        end else if (do_write) begin
            unique case (addr)
                `SWB_ADDR_SWITCH: switch_q <= data;
                `SWB_ADDR_CFG: cfg_q <= data & `SWB_CFG_MASK;
                `SWB_ADDR_BURST: burst_q <= data & `SWB_BURST_MASK;
                `SWB_ADDR_KEY: key_q <= data;
                default: ;
            endcase
        end
    end

    // any command other than the first key byte disarms the key
    always_ff @(posedge sys_clk) begin
        if (!rst_n || soft_rst) begin
            armed_q <= 1'b0;
        end else if (exec) begin
            armed_q <= do_write & (addr == `SWB_ADDR_KEY) & (data == `SWB_KEY_FIRST);
        end
    end

    // sticky flags; a set in the clearing cycle survives
    always_ff @(posedge sys_clk) begin
        if (!rst_n || soft_rst) begin
            flag_q <= `SWB_STATUS_RESET;
        end else if (ce) begin
            flag_q <= (((exec & crc_ok & is_clear) ? `SWB_ZERO8 : flag_q) | flag_set) & `SWB_STATUS_MASK;
        end
    end

    // response shifting, msb first on falling serial edges
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            resp_q <= '0;
            fresh_q <= 1'b0;
            sdo_q <= 1'b0;
            oe_n_q <= 1'b1;
        end else if (ce) begin
            oe_n_q <= lvl[2];
            if (word_done) begin
                resp_q <= {`SWB_ALIGN, (exec & is_rd) ? rd_data : `SWB_ZERO8, `SWB_ZERO8};
                fresh_q <= 1'b1;
            end else if (cs_fall) begin
                sdo_q <= resp_q[`SWB_SH_MSB];
                fresh_q <= 1'b0;
            end else if (sclk_fall && active) begin
                if (fresh_q) begin
                    sdo_q <= resp_q[`SWB_SH_MSB];
                    fresh_q <= 1'b0;
                end else begin
                    resp_q <= {resp_q[22:0], 1'b0};
                    sdo_q <= resp_q[22];
                end
            end
        end
    end

    assign sdo = sdo_q;
    assign sdo_oe_n = oe_n_q;
    assign switch_one_close = switch_q[0];
    assign switch_two_close = switch_q[1];
    assign switch_three_close = switch_q[2];
    assign switch_four_close = switch_q[3];
    assign switch_five_close = switch_q[4];
    assign switch_six_close = switch_q[5];
    assign switch_seven_close = switch_q[6];
    assign switch_eight_close = switch_q[7];

    // serial clocks per frame, watched by the checks below
    logic [9:0] tot_q;
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !active) begin
            tot_q <= '0;
        end else if (ce && sclk_rise) begin
            tot_q <= tot_q + 10'h001;
        end
    end

    // length setting changed inside the frame
    logic cfg_moved_q;
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !active) begin
            cfg_moved_q <= 1'b0;
        end else if (do_write && (soft_rst || addr == `SWB_ADDR_CFG || addr == `SWB_ADDR_BURST)) begin
            cfg_moved_q <= 1'b1;
        end
    end

    a_switch_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        do_write && !soft_rst && addr == `SWB_ADDR_SWITCH |=> {switch_eight_close, switch_seven_close,
        switch_six_close, switch_five_close, switch_four_close, switch_three_close, switch_two_close,
        switch_one_close} == $past(data))
        else $error("switch outputs do not follow written state");
    a_switch_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !do_write |=> $stable(switch_q))
        else $error("switch state changed without a write");
    a_cfg_reset: assert property (@(posedge sys_clk)
        $rose(rst_n) |-> cfg_q == `SWB_CFG_RESET && flag_q == `SWB_STATUS_RESET && burst_q == `SWB_BURST_RESET)
        else $error("register defaults wrong after reset");
    a_addr_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
        exec && crc_ok && !is_clear && !addr_ok && !soft_rst
        |=> flag_q[`SWB_FLAG_ADDR] == $past(cfg_q[`SWB_CFG_ADDR_CHK]) || $past(flag_q[`SWB_FLAG_ADDR]))
        else $error("invalid address flag wrong");
    a_cnt_sixteen: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ce && cs_rise && cfg_q[`SWB_CFG_CNT_CHK] && !cfg_q[`SWB_CFG_CRC] && !burst_q[`SWB_BURST_BIT]
        && !cfg_moved_q && tot_q != 10'(`SWB_LEN_PLAIN) |=> flag_q[`SWB_FLAG_CNT])
        else $error("bad count of 16 not flagged");
    a_cnt_twentyfour: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ce && cs_rise && cfg_q[`SWB_CFG_CNT_CHK] && cfg_q[`SWB_CFG_CRC] && !burst_q[`SWB_BURST_BIT]
        && !cfg_moved_q && tot_q != 10'(`SWB_LEN_CRC) |=> flag_q[`SWB_FLAG_CNT])
        else $error("bad count of 24 not flagged");
    a_cnt_burst: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ce && cs_rise && burst_q[`SWB_BURST_BIT] && !cfg_q[`SWB_CFG_CRC] && !cfg_moved_q && tot_q != '0
        && tot_q % `SWB_LEN_PLAIN == 0 && !flag_q[`SWB_FLAG_CNT]
        |=> !flag_q[`SWB_FLAG_CNT])
        else $error("burst multiple of 16 wrongly flagged");
    a_cnt_disabled: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !cfg_q[`SWB_CFG_CNT_CHK] && !flag_q[`SWB_FLAG_CNT] |=> !flag_q[`SWB_FLAG_CNT])
        else $error("count flag set while check disabled");
    a_burst_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        do_write && !soft_rst && addr == `SWB_ADDR_BURST |=> burst_q == ($past(data) & `SWB_BURST_MASK))
        else $error("burst enable not written");
    a_soft_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
        do_write && addr == `SWB_ADDR_KEY && data == `SWB_KEY_SECOND && armed_q
        |=> cfg_q == `SWB_CFG_RESET && switch_q == `SWB_SWITCH_RESET && flag_q == `SWB_STATUS_RESET)
        else $error("key sequence did not restore defaults");
    a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
        exec && is_rd && addr == `SWB_ADDR_CFG |=> resp_q[15:11] == 5'h00)
        else $error("reserved configuration bits read nonzero");
endmodule // swb_core

// ---- tb/swb_host.sv ----
/*
 * Behavioural serial host: mode 0 frames, clock idles low between frames.
 * Assumes sys_clk at 100 ns; every pin change lands on a sys_clk falling edge.
 */
`timescale 1ns/100ps
module swb_host (
    input wire logic sys_clk,
    input wire logic sdo,
    output logic sclk,
    output logic cs_n,
    output logic sdi
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end

    // n bits of w msb first; sdo captured late in the high phase
    task automatic frame(input logic [47:0] w, input int n, output logic [47:0] r);
        r = '0;
        @(negedge sys_clk);
        cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            sdi = w[47-i];
            #400;
            sclk = 1'b1;
            #330;
            r[47-i] = sdo;
            #70;
            sclk = 1'b0;
        end
        #400;
        cs_n = 1'b1;
        // released line shows no stale value
        sdi = ~sdi;
        #1000;
    endtask
endmodule // swb_host

// ---- tb/test_swb_core.sv ----
/*
 * Self-checking bench of the switch register bank against an integer model.
 * Assumes the host model above and responses one frame late on sdo.
 */
`timescale 1ns/100ps
module test_swb_core;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic sclk, cs_n, sdi, sdo, sdo_oe_n;
    logic [7:0] sw_out;
    int err_total = 0;
    int comparisons = 0;
    int m_sw, m_cfg, m_flg, m_bst, m_key, armed, resp;
    logic [47:0] r_frz;

    always #50 sys_clk = ~sys_clk;

    swb_host host (.sys_clk(sys_clk), .sdo(sdo), .sclk(sclk), .cs_n(cs_n), .sdi(sdi));

    swb_core DUT (
        .sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
        .sdo(sdo), .sdo_oe_n(sdo_oe_n),
        .switch_one_close(sw_out[0]), .switch_two_close(sw_out[1]), .switch_three_close(sw_out[2]),
        .switch_four_close(sw_out[3]), .switch_five_close(sw_out[4]), .switch_six_close(sw_out[5]),
        .switch_seven_close(sw_out[6]), .switch_eight_close(sw_out[7])
    );

    task automatic print_verdict();
        if (err_total == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string name, input int exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp[15:0]) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", name, exp[15:0], got);
        end
    endtask

    function automatic logic [7:0] crc8(input int d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction

    task automatic defaults();
        m_sw = 0;
        m_cfg = 6;
        m_flg = 0;
        m_bst = 0;
        m_key = 0;
    endtask

    task automatic exec(input int c);
        int a;
        int d;
        int ok;
        a = (c >> 8) & 8'h7f;
        d = c & 8'hff;
        ok = (a == 1 || a == 2 || a == 5 || a == 8'h0b || (c[15] && a == 3));
        resp = ok ? 16'h2500 : -1;
        if (c == 16'h6ca9) begin
            m_flg = 0;
            resp = 16'h2500;
        end else if (!ok) begin
            if (m_cfg[2]) m_flg |= 4;
        end else if (c[15]) begin
            resp |= a == 1 ? m_sw : a == 2 ? m_cfg : a == 3 ? m_flg : a == 5 ? m_bst : m_key;
        end else begin
            if (a == 1) m_sw = d;
            if (a == 2) m_cfg = d & 7;
            if (a == 5) m_bst = d & 1;
            if (a == 8'h0b) m_key = d;
            if (armed && a == 8'h0b && d == 5) defaults();
        end
        armed = (c == 16'h0ba3);
    endtask

    task automatic xfer(input int c0, input int c1, input int n, input int bad);
        int len;
        logic [47:0] w;
        logic [47:0] r;
        len = m_cfg[0] ? 24 : 16;
        if (len == 24) w = {c0[15:0], crc8(c0) ^ bad[7:0], c1[15:0], crc8(c1)};
        else w = {c0[15:0], c1[15:0], 16'h0000};
        host.frame(w, n, r);
        if (resp >= 0) chk("sdo", resp, r[47:32]);
        resp = -1;
        if (n >= len && bad == 0) exec(c0);
        else if (n >= len) m_flg |= 1;
        if (m_bst[0] && n >= 2 * len) exec(c1);
        if (m_cfg[1] && (m_bst[0] ? n % len != 0 : n != len)) m_flg |= 2;
        if (m_bst[0] ? n % len != 0 : n != len) resp = -1;
        chk("switches", m_sw, {8'h00, sw_out});
        chk("sdo_oe_n", 1, {15'h0000, sdo_oe_n});
    endtask

    task automatic cmd(input int c);
        xfer(c, 0, m_cfg[0] ? 24 : 16, 0);
    endtask

    initial begin
        #5ms;
        err_total++;
        print_verdict();
    end

    initial begin
        void'($urandom(32'h43f5));
        defaults();
        armed = 0;
        resp = -1;
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_n = 1'b1;
        cmd(16'h8100);
        cmd(16'h8200);
        cmd(16'h8300);
        cmd(16'h8500);
        cmd(16'h8b00);
        cmd(16'h8400);
        cmd(16'h8300);
        cmd(16'h6ca9);
        repeat (4) cmd(16'h0100 | ($urandom() & 8'hff));
        ce = 1'b0;
        host.frame({16'h01c3, 32'h0}, 16, r_frz);
        ce = 1'b1;
        chk("switches_frozen", m_sw, {8'h00, sw_out});
        xfer(16'h0155, 0, 17, 0);
        cmd(16'h8300);
        cmd(16'h6ca9);
        cmd(16'h0202);
        cmd(16'h0400);
        xfer(16'h0100, 0, 15, 0);
        cmd(16'h0200);
        xfer(16'h01aa, 0, 20, 0);
        cmd(16'h0203);
        xfer(16'h0133, 0, 16, 0);
        xfer(16'h0144, 0, 24, 1);
        cmd(16'h8300);
        cmd(16'h6ca9);
        cmd(16'h0501);
        xfer(16'h0111, 16'h01ee, 48, 0);
        xfer(16'h0122, 16'h0100, 40, 0);
        cmd(16'h8300);
        cmd(16'h0ba3);
        cmd(16'h0b05);
        cmd(16'h8200);
        cmd(16'h8500);
        cmd(16'h8300);
        cmd(16'h8b00);
        cmd(16'h0501);
        xfer(16'h0166, 16'h0177, 32, 0);
        xfer(16'h0188, 0, 24, 0);
        cmd(16'h8300);
        cmd(16'h8100);
        print_verdict();
    end
endmodule // test_swb_core
